// file: hdl/wcc_defines.svh
`ifndef WCC_DEFINES_SVH
`define WCC_DEFINES_SVH
// off time 0.69 times the timing network product, default 30 us
`define WCC_OFF_TIME_NS        30000
`define WCC_CLK_PERIOD_NS      20
`define WCC_OFF_CYCLES         ((`WCC_OFF_TIME_NS) / (`WCC_CLK_PERIOD_NS))
`define WCC_CNT_W              16
`define WCC_CUR_FULL           2'b00
`define WCC_CUR_60             2'b01
`define WCC_CUR_19             2'b10
`define WCC_CUR_INHIBIT        2'b11
`define WCC_ADDR_CTRL          4'h0
`define WCC_ADDR_STEP          4'h1
`define WCC_ADDR_STATUS        4'h2
`define WCC_ADDR_OFFCNT        4'h3
`define WCC_MODE_WAVE          2'b00
`define WCC_MODE_FULL          2'b01
`define WCC_MODE_HALF          2'b10
`define WCC_PIN_IDLE           2'b11
`define WCC_CMP_IDLE           2'b00
`define WCC_CTRL_FLOAT         6
`endif

// file: hdl/wcc_pkg.sv
`default_nettype none
package wcc_pkg;
    typedef enum logic [1:0] {
        WCC_LVL_FULL    = 2'b00,
        WCC_LVL_60      = 2'b01,
        WCC_LVL_19      = 2'b10,
        WCC_LVL_OFF     = 2'b11
    } wcc_level_t;
    typedef enum logic [2:0] {
        WCC_ST_IDLE     = 3'b001,
        WCC_ST_ON       = 3'b010,
        WCC_ST_CHOP     = 3'b100
    } wcc_state_t;
endpackage : wcc_pkg
`default_nettype wire

// file: hdl/wcc_if.sv
`default_nettype none
// logic pins between sequencer and one winding channel; inputs float high
interface wcc_if;
    logic direction;
    logic current_select_bit0;
    logic current_select_bit1;
    logic direction_oe;
    logic select_oe;
    modport device (input direction, current_select_bit0, current_select_bit1, direction_oe, select_oe);
    modport host   (output direction, current_select_bit0, current_select_bit1, direction_oe, select_oe);
endinterface : wcc_if
`default_nettype wire

// file: hdl/wcc_chopper.sv
// Chosen here: strobed register access and the register addresses.
`include "wcc_defines.svh"
// How it works
// - comparator rising edge starts off pulse
// - pulse length is cycle count of 0.69RC
// - triggers during pulse are ignored
// - off pulse drops sinks, source stays on
// - sink returns after pulse, cycle repeats
// - direction change swaps conducting diagonal
// - half step: flip direction with inhibit
// - wave drive uses 4 step sequence
// - half step uses 8 step sequence
// - full step follows step pulse and direction
// - select 00 100%, 01 60%, 10 19%, 11 off
// - low dir: high b, low a; high: high a, low b
// - undriven logic input reads as high
`default_nettype none
module wcc_chopper (
    // system
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // logic pins
    wcc_if.device                      pins,
    // analog front end
    input  wire logic                  currentComparator,
    input  wire logic [`WCC_CNT_W-1:0] offCycles,
    // bridge
    output logic                       high_side_switch_a,
    output logic                       high_side_switch_b,
    output logic                       low_side_switch_a,
    output logic                       low_side_switch_b,
    output logic [1:0]                 currentLevel,
    output logic                       chopActive
);
    typedef struct packed {
        logic [1:0]            dirSync;
        logic [1:0]            b0Sync;
        logic [1:0]            b1Sync;
        logic [1:0]            cmpSync;
        logic                  cmpPrev;
        logic                  sampled;
        wcc_pkg::wcc_state_t   state;
        logic [`WCC_CNT_W-1:0] count;
        logic                  hsA;
        logic                  hsB;
        logic                  lsA;
        logic                  lsB;
        logic [1:0]            level;
        logic                  chop;
    } wcc_dev_t;

    wcc_dev_t cur;
    wcc_dev_t next_cur;

    // open pin (enable low) reads as high
    logic dirPin;
    logic b0Pin;
    logic b1Pin;
    assign dirPin = pins.direction_oe ? pins.direction : 1'b1;
    assign b0Pin  = pins.select_oe ? pins.current_select_bit0 : 1'b1;
    assign b1Pin  = pins.select_oe ? pins.current_select_bit1 : 1'b1;

    function automatic logic [1:0] decodeLevel(input logic b0, input logic b1);
        case ({b1, b0})
            2'b00:   decodeLevel = `WCC_CUR_FULL;
            2'b01:   decodeLevel = `WCC_CUR_60;
            2'b10:   decodeLevel = `WCC_CUR_19;
            default: decodeLevel = `WCC_CUR_INHIBIT;
        endcase
    endfunction : decodeLevel

    // one step of a two-stage synchroniser
    function automatic logic [1:0] shiftIn(input logic [1:0] sync, input logic pin);
        shiftIn = {sync[0], pin};
    endfunction : shiftIn

    function automatic logic [`WCC_CNT_W-1:0] countDown(input logic [`WCC_CNT_W-1:0] value);
        countDown = value - `WCC_CNT_W'(1);
    endfunction : countDown

    logic dir;
    logic inhibit;
    logic cmpRise;
    logic [`WCC_CNT_W-1:0] loadCount;

    always_comb begin
        next_cur         = cur;
        next_cur.dirSync = shiftIn(cur.dirSync, dirPin);
        next_cur.b0Sync  = shiftIn(cur.b0Sync, b0Pin);
        next_cur.b1Sync  = shiftIn(cur.b1Sync, b1Pin);
        next_cur.cmpSync = shiftIn(cur.cmpSync, currentComparator);
        next_cur.cmpPrev = cur.cmpSync[1];
        next_cur.sampled = 1'b1;
        dir       = cur.dirSync[1];
        next_cur.level = decodeLevel(cur.b0Sync[1], cur.b1Sync[1]);
        inhibit   = (next_cur.level == `WCC_CUR_INHIBIT);
        cmpRise   = cur.cmpSync[1] & ~cur.cmpPrev & cur.sampled;
        // zero count would wrap to the maximum; least pulse is one cycle
        loadCount = (offCycles == '0) ? `WCC_CNT_W'(1) : offCycles;
        case (cur.state)
            wcc_pkg::WCC_ST_IDLE: begin
                if (cur.sampled) begin
                    next_cur.state = wcc_pkg::WCC_ST_ON;
                end
            end
            wcc_pkg::WCC_ST_ON: begin
                if (cmpRise) begin
                    next_cur.state = wcc_pkg::WCC_ST_CHOP;
                    next_cur.count = countDown(loadCount);
                end
            end
            wcc_pkg::WCC_ST_CHOP: begin
                // edges here are dropped, not queued
                if (cur.count == '0) begin
                    next_cur.state = wcc_pkg::WCC_ST_ON;
                end else begin
                    next_cur.count = countDown(cur.count);
                end
            end
            default: begin
                next_cur.state = wcc_pkg::WCC_ST_IDLE;
            end
        endcase
        if (next_cur.state == wcc_pkg::WCC_ST_IDLE || inhibit) begin
            next_cur.hsA = 1'b0;
            next_cur.hsB = 1'b0;
            next_cur.lsA = 1'b0;
            next_cur.lsB = 1'b0;
        end else begin
            // diagonal follows direction; swapping turns old pair off
            next_cur.hsA = dir;
            next_cur.hsB = ~dir;
            next_cur.lsA = ~dir & (next_cur.state != wcc_pkg::WCC_ST_CHOP);
            next_cur.lsB = dir & (next_cur.state != wcc_pkg::WCC_ST_CHOP);
        end
        // registered copy so the pulse output leaves a flop, not a decode
        next_cur.chop = (next_cur.state == wcc_pkg::WCC_ST_CHOP);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // pins start at their open level, so the bridge stays inhibited until synced
            cur <= '{
                dirSync: `WCC_PIN_IDLE,
                b0Sync:  `WCC_PIN_IDLE,
                b1Sync:  `WCC_PIN_IDLE,
                cmpSync: `WCC_CMP_IDLE,
                cmpPrev: 1'b0,
                sampled: 1'b0,
                state:   wcc_pkg::WCC_ST_IDLE,
                count:   '0,
                hsA:     1'b0,
                hsB:     1'b0,
                lsA:     1'b0,
                lsB:     1'b0,
                level:   `WCC_CUR_INHIBIT,
                chop:    1'b0
            };
        end else begin
            cur <= next_cur;
        end
    end

    assign high_side_switch_a = cur.hsA;
    assign high_side_switch_b = cur.hsB;
    assign low_side_switch_a  = cur.lsA;
    assign low_side_switch_b  = cur.lsB;
    assign currentLevel       = cur.level;
    assign chopActive         = cur.chop;
endmodule : wcc_chopper
`default_nettype wire

// file: hdl/wcc_sequencer.sv
`include "wcc_defines.svh"
`default_nettype none
module wcc_sequencer (
    // system
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [15:0] rdData,
    // winding pins
    wcc_if.host              windA,
    wcc_if.host              windB
);
    typedef struct packed {
        logic [1:0]  mode;
        logic        reverse;
        logic        enable;
        logic        pinsDriven;
        logic [1:0]  level;
        logic [2:0]  phase;
        logic        dirA;
        logic        dirB;
        logic        inhA;
        logic        inhB;
        logic [15:0] rd;
        logic [15:0] steps;
    } wcc_seq_t;

    wcc_seq_t cur;
    wcc_seq_t next_cur;

    // half-step pattern, phase 0..7: {dirA, inhA, dirB, inhB}
    function automatic logic [3:0] halfPattern(input logic [2:0] p);
        case (p)
            3'h0:    halfPattern = 4'h0;
            3'h1:    halfPattern = 4'h3; // B inhibited, dir flipped with it
            3'h2:    halfPattern = 4'h2;
            3'h3:    halfPattern = 4'he;
            3'h4:    halfPattern = 4'ha;
            3'h5:    halfPattern = 4'h9;
            3'h6:    halfPattern = 4'h8;
            default: halfPattern = 4'h4;
        endcase
    endfunction : halfPattern

    logic [3:0] pat;
    logic [2:0] stepPhase;

    always_comb begin
        next_cur  = cur;
        pat       = 4'h0;
        next_cur.rd = 16'h0000;
        if (wrStb && addr == `WCC_ADDR_CTRL) begin
            next_cur.mode    = wrData[1:0];
            next_cur.reverse = wrData[2];
            next_cur.enable  = wrData[3];
            next_cur.level   = wrData[5:4];
            next_cur.pinsDriven = ~wrData[`WCC_CTRL_FLOAT];
        end
        stepPhase = cur.reverse ? cur.phase - 3'h1 : cur.phase + 3'h1;
        if (wrStb && addr == `WCC_ADDR_STEP && cur.enable) begin
            next_cur.phase = (cur.mode == `WCC_MODE_HALF) ? stepPhase : {1'b0, stepPhase[1:0]};
            next_cur.steps = cur.steps + 16'h0001;
        end
        case (cur.mode)
            `WCC_MODE_WAVE: begin
                // one winding at a time
                pat = {cur.phase[1], ~cur.phase[0], cur.phase[1], cur.phase[0]};
            end
            `WCC_MODE_FULL: begin
                pat = {cur.phase[1], 1'b0, cur.phase[1] ^ cur.phase[0], 1'b0};
            end
            default: begin
                pat = halfPattern(cur.phase);
            end
        endcase
        next_cur.dirA = pat[3];
        next_cur.inhA = pat[2] | ~cur.enable;
        next_cur.dirB = pat[1];
        next_cur.inhB = pat[0] | ~cur.enable;
        if (rdStb) begin
            case (addr)
                `WCC_ADDR_CTRL:   next_cur.rd = {9'h000, ~cur.pinsDriven, cur.level, cur.enable, cur.reverse, cur.mode};
                `WCC_ADDR_STATUS: next_cur.rd = {9'h000, cur.phase, cur.dirA, cur.inhA, cur.dirB, cur.inhB};
                `WCC_ADDR_OFFCNT: next_cur.rd = cur.steps;
                default:          next_cur.rd = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= '{mode: `WCC_MODE_WAVE, reverse: 1'b0, enable: 1'b0, level: `WCC_CUR_FULL,
                     phase: 3'h0, dirA: 1'b0, dirB: 1'b0, inhA: 1'b1, inhB: 1'b1,
                     rd: 16'h0000, steps: 16'h0000, pinsDriven: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end

    // inhibit shows as select 11 on the pins
    assign windA.direction           = cur.dirA;
    assign windA.current_select_bit0 = cur.inhA | cur.level[0];
    assign windA.current_select_bit1 = cur.inhA | cur.level[1];
    // released pins let the device see its open-input level
    assign windA.direction_oe        = cur.pinsDriven;
    assign windA.select_oe           = cur.pinsDriven;
    assign windB.direction           = cur.dirB;
    assign windB.current_select_bit0 = cur.inhB | cur.level[0];
    assign windB.current_select_bit1 = cur.inhB | cur.level[1];
    assign windB.direction_oe        = cur.pinsDriven;
    assign windB.select_oe           = cur.pinsDriven;
    assign rdData                    = cur.rd;
endmodule : wcc_sequencer
`default_nettype wire

// file: dv/wcc_chopper_properties.sv
`default_nettype none
module wcc_chopper_properties (
    // system
    input wire logic        clk,
    input wire logic        rst_n,
    // pin and bridge
    input wire logic        direction,
    input wire logic        currentComparator,
    input wire logic [15:0] offCycles,
    input wire logic        high_side_switch_a,
    input wire logic        high_side_switch_b,
    input wire logic        low_side_switch_a,
    input wire logic        low_side_switch_b,
    input wire logic [1:0]  currentLevel,
    input wire logic        chopActive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] chopLen;
    // cycles spent in the current off pulse
    always_ff @(posedge clk) begin
        chopLen <= chopActive ? chopLen + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_trigger;
        $rose(chopActive) |-> $past(currentComparator, 2) || $past(currentComparator, 3);
    endproperty
    a_trigger: assert property (p_trigger) else $error("pulse without comparator");
    property p_length;
        $fell(chopActive) |-> chopLen == offCycles;
    endproperty
    a_length: assert property (p_length) else $error("off pulse length wrong");
    property p_sinks_off;
        chopActive |-> !low_side_switch_a && !low_side_switch_b;
    endproperty
    a_sinks_off: assert property (p_sinks_off) else $error("sink on in pulse");
    property p_source_on;
        chopActive && currentLevel != 2'b11 |-> high_side_switch_a || high_side_switch_b;
    endproperty
    a_source_on: assert property (p_source_on) else $error("source off in pulse");
    property p_sink_back;
        $fell(chopActive) && currentLevel != 2'b11 |-> ##[0:1] (low_side_switch_a || low_side_switch_b);
    endproperty
    a_sink_back: assert property (p_sink_back) else $error("sink not back");
    property p_diagonal;
        $stable(direction)[*5] ##0 (!chopActive && currentLevel != 2'b11) |-> high_side_switch_a == direction
            && low_side_switch_b == direction && high_side_switch_b != direction && low_side_switch_a != direction;
    endproperty
    a_diagonal: assert property (p_diagonal) else $error("wrong diagonal");
    property p_inhibit;
        currentLevel == 2'b11 |-> !(high_side_switch_a || high_side_switch_b || low_side_switch_a || low_side_switch_b);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("switch on while inhibited");
    property p_reset;
        $rose(rst_n) |-> currentLevel == 2'b11 && !chopActive
            && !(high_side_switch_a || high_side_switch_b || low_side_switch_a || low_side_switch_b);
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_no_shoot;
        !(high_side_switch_a && low_side_switch_a) && !(high_side_switch_b && low_side_switch_b);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("one bridge leg fully on");
    c_chop: cover property ($rose(chopActive));
    c_dir: cover property ($changed(direction));
    c_inhibit: cover property ($rose(currentLevel == 2'b11));
endmodule : wcc_chopper_properties
`default_nettype wire

// file: dv/wcc_chopper_tb.sv
`default_nettype none
module wcc_chopper_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wrData = 16'h0000;
    logic        wrStb = 1'b0;
    logic        rdStb = 1'b0;
    logic        currentComparator = 1'b0;
    logic [15:0] offCycles = 16'h0014;
    logic [15:0] rdData, st, st0, prev;
    logic        hsa, hsb, lsa, lsb, chopActive;
    logic [1:0]  currentLevel;
    int          fails = 0;
    int          check_count = 0;
    int          k;
    wcc_if ifA ();
    wcc_if ifB ();
    always #10 clk = ~clk;
    wcc_sequencer u_wcc_sequencer (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .windA(ifA), .windB(ifB));
    wcc_chopper u_wcc_chopper (.clk(clk), .rst_n(rst_n), .pins(ifA), .currentComparator(currentComparator),
        .offCycles(offCycles), .high_side_switch_a(hsa), .high_side_switch_b(hsb), .low_side_switch_a(lsa),
        .low_side_switch_b(lsb), .currentLevel(currentLevel), .chopActive(chopActive));
    wcc_chopper_properties u_props (.clk(clk), .rst_n(rst_n), .direction(ifA.direction),
        .currentComparator(currentComparator), .offCycles(offCycles), .high_side_switch_a(hsa),
        .high_side_switch_b(hsb), .low_side_switch_a(lsa), .low_side_switch_b(lsb),
        .currentLevel(currentLevel), .chopActive(chopActive));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // trailing idle edge so the next strobe never lands in the same step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        @(negedge clk);
        d = rdData;
        @(posedge clk);
    endtask : rd
    task automatic finish_test();
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset level", 16'(currentLevel), 16'h0003);
        chk("reset switches", 16'({hsa, hsb, lsa, lsb}), 16'h0000);
        @(posedge clk);
        rd(4'hf, st);
        chk("unmapped", st, 16'h0000);
        wr(4'h1, 16'h0000);
        rd(4'h2, st);
        chk("step while disabled", st, 16'h0005);
        rd(4'h3, st);
        chk("step count idle", st, 16'h0000);
        for (int m = 0; m < 3; m++) begin
            wr(4'h0, 16'h0008 | 16'(m));
            wr(4'h1, 16'h0000);
            rd(4'h2, st0);
            prev = st0;
            for (int s = 1; s <= 8; s++) begin
                wr(4'h1, 16'h0000);
                rd(4'h2, st);
                k = int'(!st[2]) + int'(!st[0]);
                if (m == 0) begin
                    chk("wave", 16'(k), 16'h0001);
                end else if (m == 1) begin
                    chk("full", 16'(k), 16'h0002);
                end else begin
                    chk("half", 16'(k), 16'(3 - int'(!prev[2]) - int'(!prev[0])));
                    if (st[2] && !prev[2]) begin
                        chk("half dir", 16'(st[3]), 16'(!prev[3]));
                    end
                    if (st[0] && !prev[0]) begin
                        chk("half dir b", 16'(st[1]), 16'(!prev[1]));
                    end
                end
                if (s % (m == 2 ? 8 : 4) == 0) begin
                    chk("period", 16'(st[3:0]), 16'(st0[3:0]));
                end
                prev = st;
            end
        end
        wr(4'h0, 16'h0009);
        rd(4'h0, st);
        chk("ctrl readback", st, 16'h0009);
        rd(4'h2, prev);
        wr(4'h1, 16'h0000);
        rd(4'h2, st0);
        wr(4'h0, 16'h000d);
        wr(4'h1, 16'h0000);
        rd(4'h2, st);
        chk("reverse", 16'(st[6:0]), 16'(prev[6:0]));
        wr(4'h0, 16'h0009);
        wr(4'h1, 16'h0000);
        rd(4'h2, st);
        chk("forward", 16'(st[3:0]), 16'(st0[3:0]));
        rd(4'h3, st);
        chk("step count", st, 16'h001e);
        for (int lv = 0; lv < 4; lv++) begin
            wr(4'h0, 16'h0009 | 16'(lv << 4));
            repeat (6) @(negedge clk);
            chk("level", 16'(currentLevel), 16'(lv));
            chk("diagonal", 16'({hsa, lsb, hsb, lsa}),
                16'(lv == 3 ? 4'h0 : {{2{ifA.direction}}, {2{!ifA.direction}}}));
            chk("winding b select", 16'({ifB.current_select_bit1, ifB.current_select_bit0}), 16'(lv));
            @(posedge clk);
        end
        // released pins must read high, which decodes as inhibit
        wr(4'h0, 16'h0049);
        repeat (6) @(negedge clk);
        chk("open pins level", 16'(currentLevel), 16'h0003);
        chk("open pins bridge", 16'({hsa, hsb, lsa, lsb}), 16'h0000);
        @(posedge clk);
        wr(4'h0, 16'h0009);
        repeat (6) @(posedge clk);
        for (int n = 1; n <= 20; n += 19) begin
            offCycles <= 16'(n);
            currentComparator <= 1'b1;
            k = 0;
            while (!chopActive && k < 10) begin
                @(negedge clk);
                k++;
            end
            chk("chop start", 16'(k <= 5), 16'h0001);
            k = 0;
            // comparator keeps toggling to try a retrigger
            while (chopActive && k < 100) begin
                @(posedge clk);
                currentComparator <= k[1];
                @(negedge clk);
                k++;
            end
            chk("off length", 16'(k), 16'(n));
            @(posedge clk);
            currentComparator <= 1'b0;
            repeat (30) @(posedge clk);
        end
        finish_test();
    end
endmodule : wcc_chopper_tb
`default_nettype wire
